/* src/wdg_top.sv */
// module: watchdog reset counter with apb registers and reset pulse generator
//
// Overview of operation
// [RULE_01] 6-bit counter behind 12-bit oscillator prescaler
// [RULE_02] unserviced overflow raises asynchronous system reset
// [RULE_03] rate one 8176 cycles, zero 262128
// [RULE_04] service write clears counter, prescaler stages 4-12
// [RULE_05] service address reads reset vector low byte
// [RULE_06] reset pin low 32 cycles, cause bit set
// [RULE_07] monitor mode with test voltage disables
// [RULE_08] break with test voltage on reset disables
// [RULE_09] executed stop instruction clears prescaler
// [RULE_10] power-on clears prescaler after 4096 cycles
// [RULE_11] internal reset clears prescaler and counter
// [RULE_12] reset vector fetch clears prescaler
// [RULE_13] disable bit one turns watchdog off
// [RULE_14] no cpu interrupt, only reset output
// [RULE_15] counting continues in wait mode
// [RULE_16] stop mode gates clock, clears prescaler
// [RULE_17] stop enable zero makes stop illegal
// [RULE_18] configuration write-once, held until reset
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
module wdg_top
  import wdg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_tick,
  input wire logic monitor_mode,
  input wire logic tst_on_irq_pin,
  input wire logic tst_on_rst_pin,
  input wire logic break_active,
  input wire logic stop_instr,
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic int_reset,
  input wire logic vec_fetch,
  input wire logic [7:0] reset_vector_lo,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic sys_reset_req,
  output logic stop_exec,
  output logic stop_illegal
);
  wdg_if w ();

  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [CFG_W-1:0] cfg_r;
  logic cfg_lock_r;
  logic cause_r;
  wdg_state_t state_r;
  wdg_state_t state_nxt;
  logic [4:0] pulse_cnt_r;
  logic rst_pin_oe_r;
  logic sys_reset_req_r;
  logic stop_exec_r;
  logic stop_illegal_r;
  logic setup;
  logic access;
  logic wr;
  logic svc_wr;
  logic cfg_wr;
  logic stat_wr;
  logic stop_ok;
  logic pulse_end;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == ADDR_SVC) || (a == ADDR_CFG) || (a == ADDR_STAT);
  endfunction

  function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == ADDR_SVC) begin
      // the service location overlays the vector, so no watchdog state is visible here
      d[7:0] = reset_vector_lo; // [RULE_05]
    end else if (a == ADDR_CFG) begin
      d[CFG_W-1:0] = cfg_r;
    end else if (a == ADDR_STAT) begin
      d[STAT_CAUSE_BIT] = cause_r;
      d[STAT_RUN_BIT] = w.enable;
      d[STAT_LOCK_BIT] = cfg_lock_r;
      d[STAT_CNT_LSB +: CNT_W] = w.count;
    end
    read_mux = d;
  endfunction

  assign setup = psel & ~penable;
  assign access = psel & penable & pready_r;
  assign wr = access & pwrite;
  assign svc_wr = wr & (paddr == ADDR_SVC);
  assign cfg_wr = wr & (paddr == ADDR_CFG);
  assign stat_wr = wr & (paddr == ADDR_STAT);
  assign stop_ok = cfg_r[CFG_STOPEN_BIT];
  assign pulse_end = (state_r == ST_PULSE) & osc_tick & (pulse_cnt_r == RST_PULSE_LAST);

  // wait mode is deliberately not a term here: the count must keep running
  assign w.tick = osc_tick & ~stop_mode; // [RULE_15] [RULE_16]
  assign w.enable = ~cfg_r[CFG_DIS_BIT] // [RULE_13]
    & ~(monitor_mode & (tst_on_irq_pin | tst_on_rst_pin)) // [RULE_07]
    & ~(break_active & tst_on_rst_pin); // [RULE_08]
  assign w.rate_sel = cfg_r[CFG_RATE_BIT]; // [RULE_03]
  assign w.clr_svc = svc_wr; // [RULE_04]
  assign w.clr_pre = (stop_instr & stop_ok) | stop_mode | vec_fetch; // [RULE_09] [RULE_12] [RULE_16]
  // the watchdog's own reset counts as an internal reset while the pulse lasts
  assign w.clr_all = int_reset | (state_r == ST_PULSE); // [RULE_11]

  wdg_core u_core (
    .pclk(pclk),
    .presetn(presetn),
    .w(w)
  );

  // apb slave: answer is prepared in the setup cycle, so access never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~is_mapped(paddr);
      if (setup && !pwrite) begin
        prdata_r <= read_mux(paddr);
      end else if (setup) begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // configuration: a second write is silently ignored, not an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RESET; // [RULE_03]
      cfg_lock_r <= 1'b0;
    end else if (cfg_wr && !cfg_lock_r) begin
      cfg_r <= pwdata[CFG_W-1:0]; // [RULE_18]
      cfg_lock_r <= 1'b1; // [RULE_18]
    end
  end

  // cause bit: a new watchdog reset wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_r <= 1'b0;
    end else if (w.timeout) begin
      cause_r <= 1'b1; // [RULE_06]
    end else if (stat_wr && pwdata[STAT_CAUSE_BIT]) begin
      cause_r <= 1'b0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (w.timeout) begin
          state_nxt = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (pulse_end) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // pulse length is counted in oscillator ticks, not bus clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_r <= 5'h00;
    end else if (state_r != ST_PULSE) begin
      pulse_cnt_r <= 5'h00;
    end else if (osc_tick) begin
      pulse_cnt_r <= pulse_cnt_r + 5'h01; // [RULE_06]
    end
  end

  // the reset is the only output action; there is no interrupt request at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_pin_oe_r <= 1'b0;
      sys_reset_req_r <= 1'b0;
    end else begin
      rst_pin_oe_r <= (state_nxt == ST_PULSE); // [RULE_06]
      sys_reset_req_r <= (state_nxt == ST_PULSE); // [RULE_02] [RULE_14]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_exec_r <= 1'b0;
      stop_illegal_r <= 1'b0;
    end else begin
      stop_exec_r <= stop_instr & stop_ok; // [RULE_17]
      stop_illegal_r <= stop_instr & ~stop_ok; // [RULE_17]
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  // open-drain reset pin: only ever pulled low, enable marks the drive
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = rst_pin_oe_r;
  assign sys_reset_req = sys_reset_req_r;
  assign stop_exec = stop_exec_r;
  assign stop_illegal = stop_illegal_r;

  pulse_len_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
    $fell(rst_pin_oe_r) |-> $past(pulse_cnt_r) == RST_PULSE_LAST && $past(osc_tick))
    else $error("reset pulse length wrong");

  cause_set_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
    w.timeout |=> cause_r && rst_pin_oe_r && sys_reset_req_r)
    else $error("timeout did not raise reset and cause");

  svc_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
    setup && !pwrite && paddr == ADDR_SVC |=> prdata_r == {24'h000000, $past(reset_vector_lo)})
    else $error("service read did not return vector byte");

  svc_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04]
    svc_wr |=> w.count == 6'h00)
    else $error("service write did not clear counter");

  dis_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
    !w.enable |=> !w.timeout)
    else $error("timeout while watchdog disabled");

  tst_disable_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
    (monitor_mode && (tst_on_irq_pin || tst_on_rst_pin)) || (break_active && tst_on_rst_pin)
      |-> !w.enable)
    else $error("test voltage did not disable watchdog");

  stop_ill_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_17]
    stop_instr && !stop_ok |=> stop_illegal_r && !stop_exec_r)
    else $error("stop not flagged illegal");

  cfg_lock_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_18]
    cfg_lock_r && cfg_wr |=> $stable(cfg_r))
    else $error("locked configuration changed");

  stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_16]
    stop_mode && !w.clr_all && !w.clr_svc |=> $stable(w.count))
    else $error("count moved in stop mode");

  wait_run_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
    wait_mode && osc_tick && !stop_mode |-> w.tick)
    else $error("watchdog clock stopped in wait mode");

  apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready_r && (pslverr_r == !is_mapped($past(paddr))))
    else $error("apb answer wrong");
endmodule

/* src/wdg_pkg.sv */
// package: constants, register map and types of the watchdog reset counter
package wdg_pkg;
  localparam int ADDR_W = 18;
  localparam int PRE_W = 12;
  localparam int CNT_W = 6;
  localparam int CFG_W = 3;

  // the service location is printed as a word index; the byte address is four times it
  localparam logic [15:0] SVC_INDEX = 16'hFFFF;
  localparam logic [ADDR_W-1:0] ADDR_SVC = {SVC_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CFG = 18'h00000;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 18'h00004;

  localparam int CFG_DIS_BIT = 0;
  localparam int CFG_RATE_BIT = 1;
  localparam int CFG_STOPEN_BIT = 2;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;

  localparam int STAT_CAUSE_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_CNT_LSB = 8;

  // stage 4 of the prescaler is bit 3
  localparam int SVC_CLR_LSB = 3;
  localparam int TAP_FAST = 7;
  localparam int TAP_SLOW = 12;
  localparam int TIMEOUT_FAST = 8176;
  localparam int TIMEOUT_SLOW = 262128;
  localparam int TAIL_FAST = (64 << TAP_FAST) - TIMEOUT_FAST;
  localparam int TAIL_SLOW = (64 << TAP_SLOW) - TIMEOUT_SLOW;
  localparam logic [PRE_W-1:0] LAST_FAST = PRE_W'((1 << TAP_FAST) - TAIL_FAST - 1);
  localparam logic [PRE_W-1:0] LAST_SLOW = PRE_W'((1 << TAP_SLOW) - TAIL_SLOW - 1);

  localparam int RST_PULSE_CYC = 32;
  localparam logic [4:0] RST_PULSE_LAST = 5'(RST_PULSE_CYC - 1);
  localparam int POR_DELAY_CYC = 4096;
  localparam logic [12:0] POR_LAST = 13'(POR_DELAY_CYC - 1);

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_PULSE = 2'b10
  } wdg_state_t;
endpackage

/* src/wdg_if.sv */
// interface: control and status between the watchdog top and its counter core
`timescale 1ns/1ns
interface wdg_if;
  logic tick;
  logic enable;
  logic rate_sel;
  logic clr_all;
  logic clr_svc;
  logic clr_pre;
  logic timeout;
  logic [5:0] count;
  modport ctrl (output tick, enable, rate_sel, clr_all, clr_svc, clr_pre, input timeout, count);
  modport core (input tick, enable, rate_sel, clr_all, clr_svc, clr_pre, output timeout, count);
endinterface

/* src/wdg_core.sv */
// module: prescaler, 6-bit counter and power-on prescaler clear
`timescale 1ns/1ns
module wdg_core
  import wdg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  wdg_if.core w
);
  logic [PRE_W-1:0] pre_r;
  logic [CNT_W-1:0] cnt_r;
  logic [12:0] por_cnt_r;
  logic por_done_r;
  logic timeout_r;
  logic por_clr;
  logic fire;

  function automatic logic carry(input logic [PRE_W-1:0] p, input logic fast);
    carry = fast ? (&p[TAP_FAST-1:0]) : (&p[TAP_SLOW-1:0]);
  endfunction

  function automatic logic last_tick(input logic [PRE_W-1:0] p, input logic fast);
    last_tick = fast ? (p[TAP_FAST-1:0] == LAST_FAST[TAP_FAST-1:0]) : (p == LAST_SLOW);
  endfunction

  assign por_clr = w.tick & ~por_done_r & (por_cnt_r == POR_LAST);
  // rate one taps the prescaler at 128, rate zero at its full 4096 carry
  assign fire = w.tick & w.enable & (&cnt_r) & last_tick(pre_r, w.rate_sel); // [RULE_02] [RULE_03]
  assign w.timeout = timeout_r;
  assign w.count = cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else if (w.clr_all || w.clr_pre || por_clr) begin // [RULE_09] [RULE_10] [RULE_11] [RULE_12]
      pre_r <= '0;
    end else if (w.clr_svc) begin
      // low stages survive a service, so a period can be up to 7 ticks short
      pre_r <= {{(PRE_W-SVC_CLR_LSB){1'b0}}, pre_r[SVC_CLR_LSB-1:0]}; // [RULE_04]
    end else if (w.tick) begin
      pre_r <= pre_r + 1'b1; // [RULE_01]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (w.clr_all || w.clr_svc) begin // [RULE_04] [RULE_11]
      cnt_r <= '0;
    end else if (w.tick && w.enable && carry(pre_r, w.rate_sel)) begin
      cnt_r <= cnt_r + 1'b1; // [RULE_01]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt_r <= '0;
      por_done_r <= 1'b0;
    end else if (w.tick && !por_done_r) begin
      por_cnt_r <= por_cnt_r + 1'b1;
      por_done_r <= por_clr; // [RULE_10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_r <= 1'b0;
    end else begin
      timeout_r <= fire;
    end
  end

  por_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
    por_clr |-> (por_cnt_r == POR_LAST) ##1 (pre_r == '0) && por_done_r)
    else $error("prescaler not cleared after power-on delay");
  pre_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09] [RULE_12]
    w.clr_pre || w.clr_all |=> pre_r == '0)
    else $error("prescaler not cleared by stop, fetch or reset");
  overflow_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
    timeout_r |-> $past(cnt_r) == 6'h3F && $past(w.enable))
    else $error("timeout without full counter");
endmodule

/* testbench/wdg_top_test.sv */
// testbench: self-checking bench of the watchdog reset counter over apb
`timescale 1ns/1ns
module wdg_top_test;
  import wdg_pkg::*;
  typedef struct packed {
    logic [ADDR_W-1:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] exp;
    logic [31:0] mask;
    logic err;
  } wdg_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rst_pin_o, rst_pin_oe, sys_reset_req, stop_exec, stop_illegal;
  logic osc_tick = 1'b1;
  logic monitor_mode = 1'b0;
  logic tst_on_irq_pin = 1'b0;
  logic tst_on_rst_pin = 1'b0;
  logic break_active = 1'b0;
  logic stop_instr = 1'b0;
  logic stop_mode = 1'b0;
  logic wait_mode = 1'b0;
  logic int_reset = 1'b0;
  logic vec_fetch = 1'b0;
  logic [7:0] reset_vector_lo = 8'hA5;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  wdg_row_t rows[9];
  logic [3:0] pat[4];
  logic [31:0] rd, s1;
  logic er, ex, il;
  int n;

  wdg_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_tick(osc_tick), .monitor_mode(monitor_mode),
    .tst_on_irq_pin(tst_on_irq_pin), .tst_on_rst_pin(tst_on_rst_pin),
    .break_active(break_active), .stop_instr(stop_instr), .stop_mode(stop_mode),
    .wait_mode(wait_mode), .int_reset(int_reset), .vec_fetch(vec_fetch),
    .reset_vector_lo(reset_vector_lo), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
    .sys_reset_req(sys_reset_req), .stop_exec(stop_exec), .stop_illegal(stop_illegal));

  initial begin
    forever #2 pclk = ~pclk;
  end

  task automatic print_verdict();
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // timeout ceiling well above the roughly 35000 cycles the sequence needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held until pready is seen high at an edge, then released; only the
  // cycle ceiling ends a wait that never gets its answer
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rst_dut();
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic spulse(output logic e, output logic i);
    stop_instr <= 1'b1;
    @(posedge pclk);
    stop_instr <= 1'b0;
    @(posedge pclk);
    e = stop_exec;
    i = stop_illegal;
  endtask

  initial begin
    rows = '{
      '{ADDR_CFG, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b0},
      '{ADDR_CFG, 1'b1, 32'h6, 32'h0, 32'h0, 1'b0},
      '{ADDR_CFG, 1'b0, 32'h0, 32'h6, 32'hFFFFFFFF, 1'b0},
      '{ADDR_CFG, 1'b1, 32'h1, 32'h0, 32'h0, 1'b0},
      '{ADDR_CFG, 1'b0, 32'h0, 32'h6, 32'hFFFFFFFF, 1'b0},
      '{ADDR_STAT, 1'b0, 32'h0, 32'h6, 32'h7, 1'b0},
      '{ADDR_SVC, 1'b0, 32'h0, 32'hA5, 32'hFFFFFFFF, 1'b0},
      '{ADDR_SVC, 1'b1, 32'h5A, 32'h0, 32'h0, 1'b0},
      '{18'h00008, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1}};
    pat = '{4'hC, 4'hA, 4'h3, 4'h1};
    rst_dut();
    chk("reset_req", {31'h0, sys_reset_req}, 32'h0);
    repeat (POR_DELAY_CYC + 10) @(posedge pclk);
    chk("slow_no_reset", {31'h0, sys_reset_req}, 32'h0);
    for (int i = 0; i < 9; i++) begin
      apb(rows[i].a, rows[i].w, rows[i].d, rd, er);
      chk("row_data", rd & rows[i].mask, rows[i].exp);
      chk("row_err", {31'h0, er}, {31'h0, rows[i].err});
    end
    spulse(ex, il);
    chk("stop_exec", {30'h0, ex, il}, 32'h2);
    stop_mode <= 1'b1;
    apb(ADDR_STAT, 1'b0, 32'h0, s1, er);
    repeat (300) @(posedge pclk);
    apb(ADDR_STAT, 1'b0, 32'h0, rd, er);
    chk("stop_hold", rd[13:8], s1[13:8]);
    stop_mode <= 1'b0;
    wait_mode <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(ADDR_SVC, 1'b1, 32'h0, rd, er);
      repeat (TIMEOUT_FAST / 2) @(posedge pclk);
      chk("svc_no_reset", {31'h0, sys_reset_req}, 32'h0);
    end
    apb(ADDR_SVC, 1'b1, 32'h0, rd, er);
    n = 0;
    while (sys_reset_req !== 1'b1 && n < TIMEOUT_FAST + 100) begin
      @(posedge pclk);
      n++;
    end
    // prescaler bits 2:0 survive a service write, so the period may be short by 7
    chk("timeout", 32'(n >= TIMEOUT_FAST - 10 && n <= TIMEOUT_FAST + 2), 32'h1);
    chk("pin_drive", {30'h0, rst_pin_oe, rst_pin_o}, 32'h2);
    n = 0;
    while (sys_reset_req === 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("pulse_len", 32'(n), 32'(RST_PULSE_CYC));
    apb(ADDR_STAT, 1'b0, 32'h0, rd, er);
    chk("cause_set", {31'h0, rd[STAT_CAUSE_BIT]}, 32'h1);
    apb(ADDR_STAT, 1'b1, 32'h1, rd, er);
    apb(ADDR_STAT, 1'b0, 32'h0, rd, er);
    chk("cause_clr", {31'h0, rd[STAT_CAUSE_BIT]}, 32'h0);
    wait_mode <= 1'b0;
    rst_dut();
    for (int i = 0; i < 4; i++) begin
      {monitor_mode, tst_on_irq_pin, tst_on_rst_pin, break_active} <= pat[i];
      @(posedge pclk);
      apb(ADDR_STAT, 1'b0, 32'h0, rd, er);
      chk("run_bit", {31'h0, rd[STAT_RUN_BIT]}, 32'(i == 3));
    end
    {monitor_mode, tst_on_irq_pin, tst_on_rst_pin, break_active} <= 4'h0;
    apb(ADDR_CFG, 1'b1, 32'h2, rd, er);
    repeat (400) @(posedge pclk);
    int_reset <= 1'b1;
    vec_fetch <= 1'b1;
    @(posedge pclk);
    int_reset <= 1'b0;
    vec_fetch <= 1'b0;
    apb(ADDR_STAT, 1'b0, 32'h0, rd, er);
    chk("int_clear", rd[13:8], 32'h0);
    rst_dut();
    apb(ADDR_CFG, 1'b1, 32'h3, rd, er);
    spulse(ex, il);
    chk("stop_illegal", {30'h0, ex, il}, 32'h1);
    repeat (TIMEOUT_FAST + 500) @(posedge pclk);
    chk("dis_no_reset", {31'h0, sys_reset_req}, 32'h0);
    apb(ADDR_STAT, 1'b0, 32'h0, rd, er);
    chk("dis_run", {31'h0, rd[STAT_RUN_BIT]}, 32'h0);
    print_verdict();
  end
endmodule
